// ### design/emac_defines.vh
// constants for the extended-mode audio control register group
`ifndef EMAC_DEFINES_VH
`define EMAC_DEFINES_VH

`define EMAC_CLK_HZ 25000000
`define EMAC_SRC_LO_HZ 397700
`define EMAC_SRC_HI_HZ 795500
`define EMAC_FILT_SRC_HZ 7160000
`define EMAC_MUTE_MS 100
`define EMAC_ONE_SEC_MS 1000
`define EMAC_NCO_ONE 64'h0000_0001_0000_0000
`define EMAC_TRIM_SHIFT 9

`define EMAC_IDX_SRATE 8'ha1
`define EMAC_IDX_FILT 8'ha2
`define EMAC_IDX_RLD_LO 8'ha4
`define EMAC_IDX_RLD_HI 8'ha5
`define EMAC_IDX_MIC 8'ha9
`define EMAC_IDX_IRQ 8'hb1
`define EMAC_IDX_DMA 8'hb2
`define EMAC_IDX_TRIM 8'hba
`define EMAC_IDX_FM 8'hbc

`define EMAC_RST_RLD_LO 8'h00
`define EMAC_RST_RLD_HI 8'hf8
`define EMAC_RST_MIC 8'h04
`define EMAC_RST_FM 8'hb6
`define EMAC_RST_ZERO 8'h00

`define EMAC_BIT_RANGE 7
`define EMAC_BIT_MIC_EN 2
`define EMAC_BIT_OVF_IE 6
`define EMAC_BIT_HE_IE 5
`define EMAC_BIT_EXT_DRQ 6
`define EMAC_BIT_COMP_DRQ 5
`define EMAC_BIT_TRIM 6
`define EMAC_BIT_NO_MUTE 5
`define EMAC_FM_HI 7
`define EMAC_FM_LO 6

`define EMAC_LOW_BASE 9'h080
`define EMAC_HIGH_BASE 9'h100
`define EMAC_CNT_MAX 16'hffff

`define EMAC_IRQ_LINE5 4'h5
`define EMAC_IRQ_LINE7 4'h7
`define EMAC_IRQ_LINE10 4'ha
`define EMAC_DMA_CH0 2'h0
`define EMAC_DMA_CH1 2'h1
`define EMAC_DMA_CH3 2'h3
`define EMAC_CODE_A 4'h5
`define EMAC_CODE_B 4'ha
`define EMAC_CODE_C 4'hf
`define EMAC_CODE_NONE 4'h0

`endif

// ### design/emac_nco.v
// phase accumulator that turns a frequency step into a one-cycle tick
`default_nettype none
module emac_nco #(
    parameter ACC_W = 32
) (
    input wire clk,
    input wire nrst,
    input wire [ACC_W-1:0] step,
    output reg tick
);
    reg [ACC_W-1:0] acc_reg;
    wire [ACC_W:0] sum;

    assign sum = {1'b0, acc_reg} + {1'b0, step};

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            acc_reg <= {ACC_W{1'b0}};
            tick <= 1'b0;
        end else begin
            acc_reg <= sum[ACC_W-1:0];
            tick <= sum[ACC_W];
        end
    end
endmodule // emac_nco
`default_nettype wire

// ### design/emac_div.v
// divide an enable stream by a programmable count
`default_nettype none
module emac_div #(
    parameter CNT_W = 9
) (
    input wire clk,
    input wire nrst,
    input wire en,
    input wire [CNT_W-1:0] divisor,
    output reg tick
);
    reg [CNT_W-1:0] count_reg;
    wire [CNT_W-1:0] last;

    // a zero divisor would divide by two to the CNT_W, so treat it as one
    assign last = (divisor == {CNT_W{1'b0}}) ? {CNT_W{1'b0}} : divisor - 1'b1;

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            count_reg <= {CNT_W{1'b0}};
            tick <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (en) begin
                if (count_reg >= last) begin
                    count_reg <= {CNT_W{1'b0}};
                    tick <= 1'b1;
                end else begin
                    count_reg <= count_reg + 1'b1;
                end
            end
        end
    end
endmodule // emac_div
`default_nettype wire

// ### design/emac_regs.v
// extended-mode audio control registers, rate generators, transfer counter, dma and mute
`include "emac_defines.vh"
`default_nettype none

// What this block does
// - rate source is 397.7 kHz when rate bit 7 clear, 795.5 kHz when set
// - sample rate is source divided by 128-x low range or 256-x high range
// - filter clock is 7.16 MHz divided by 256 minus filter divider value
// - reload value resets to low byte 00h and high byte F8h
// - counter loads reload value at transfer start and after each overflow
// - counter counts one per dma byte and overflows past FFFFh
// - auto-initialize keeps requesting dma; overflow only raises interrupt
// - normal mode stops dma requests at overflow until a new transfer start
// - overflow raises interrupt only when overflow interrupt enable is set
// - fifo half-empty change raises interrupt in block i/o when enabled
// - interrupt control bit 4 does nothing; activate control enables pin drive
// - interrupt control bits 3:0 read back selected interrupt line code
// - extended dma enable uses request/acknowledge, else block i/o to fifo
// - dma request always driven, low when neither dma enable bit set
// - dma control bits 3:0 read back selected dma channel code
// - preamp bit selects +26 dB gain when set, set by hardware reset
// - rate-adjust bit trims master clock for exact 44.1 kHz; reset clears
// - outputs muted 100 ms after reset or wake unless delay disabled
// - fm level bits select -1.5, +1.5, 0 (default) or -3 dB
module emac_regs #(
    parameter MUTE_CYCLES = `EMAC_MUTE_MS * (`EMAC_CLK_HZ / `EMAC_ONE_SEC_MS),
    parameter MUTE_W = 22,
    parameter FILT_RESET = 8'h00
) (
    input wire clk,
    input wire nrst,
    input wire swReset,
    input wire [7:0] regIndex,
    input wire [7:0] regWrData,
    input wire regWrEn,
    input wire regRdEn,
    output reg [7:0] regRdData,
    input wire [3:0] irqSelect,
    input wire [1:0] dmaSelect,
    input wire audioActivate,
    input wire irqClear,
    output reg irqLine,
    output reg irqDriveEn,
    input wire startXfer,
    input wire autoInitMode,
    input wire fifoReady,
    input wire fifo_half_empty_flag,
    input wire dma_acknowledge_in_n,
    input wire ioReadN,
    input wire ioWriteN,
    output reg dmaRequest,
    output reg dmaRunning,
    output reg blockIoMode,
    output reg byteMoved,
    input wire analogWake,
    output reg line_output_left_mute,
    output reg line_output_right_mute,
    output reg micGain26,
    output reg rate_trim_enable,
    output reg fm_level_high_bit,
    output reg fm_level_low_bit,
    output wire sampleTick,
    output wire filterTick
);
    localparam [63:0] STEP_LO64 = (`EMAC_SRC_LO_HZ * `EMAC_NCO_ONE) / `EMAC_CLK_HZ;
    localparam [63:0] STEP_HI64 = (`EMAC_SRC_HI_HZ * `EMAC_NCO_ONE) / `EMAC_CLK_HZ;
    localparam [63:0] STEP_FI64 = (`EMAC_FILT_SRC_HZ * `EMAC_NCO_ONE) / `EMAC_CLK_HZ;
    localparam [MUTE_W-1:0] MUTE_LAST = MUTE_CYCLES[MUTE_W-1:0] - 1'b1;

    // trim raises every generated rate by about 0.2 percent
    function [31:0] trimStep;
        input [31:0] step;
        input trim;
        begin
            trimStep = trim ? step + (step >> `EMAC_TRIM_SHIFT) : step;
        end
    endfunction

    function [3:0] irqCode;
        input [3:0] line;
        begin
            case (line)
                `EMAC_IRQ_LINE5: irqCode = `EMAC_CODE_A;
                `EMAC_IRQ_LINE7: irqCode = `EMAC_CODE_B;
                `EMAC_IRQ_LINE10: irqCode = `EMAC_CODE_C;
                default: irqCode = `EMAC_CODE_NONE;
            endcase
        end
    endfunction

    function [3:0] dmaCode;
        input [1:0] chan;
        begin
            case (chan)
                `EMAC_DMA_CH0: dmaCode = `EMAC_CODE_A;
                `EMAC_DMA_CH1: dmaCode = `EMAC_CODE_B;
                `EMAC_DMA_CH3: dmaCode = `EMAC_CODE_C;
                default: dmaCode = `EMAC_CODE_NONE;
            endcase
        end
    endfunction

    reg [7:0] srate_reg;
    reg [7:0] filt_reg;
    reg [7:0] rldLo_reg;
    reg [7:0] rldHi_reg;
    reg [7:0] mic_reg;
    reg [7:4] irqCtl_reg;
    reg [7:4] dmaCtl_reg;
    reg [7:0] trim_reg;
    reg [7:0] fm_reg;
    reg [15:0] xferCnt_reg;
    reg [MUTE_W-1:0] muteCnt_reg;
    reg muting_reg;
    reg ackMeta_reg;
    reg ackSync_reg;
    reg rdMeta_reg;
    reg rdSync_reg;
    reg wrMeta_reg;
    reg wrSync_reg;
    reg wakeMeta_reg;
    reg wakeSync_reg;
    reg wakeLast_reg;
    reg cmdLow_reg;
    reg ackLow_reg;
    reg heLast_reg;
    reg inCycle_reg;

    wire wrSel;
    wire extDma;
    wire compDma;
    wire cmdLow;
    wire byteDone;
    wire overflow;
    wire heChange;
    wire irqSet;
    wire wakeRise;
    wire srcTick;
    wire [31:0] srcStep;
    wire [8:0] sampleDiv;
    wire [8:0] filterDiv;

    assign wrSel = regWrEn;
    assign extDma = dmaCtl_reg[`EMAC_BIT_EXT_DRQ];
    assign compDma = dmaCtl_reg[`EMAC_BIT_COMP_DRQ];

    // rate generator chain
    assign srcStep = srate_reg[`EMAC_BIT_RANGE] ? STEP_HI64[31:0] : STEP_LO64[31:0];
    assign sampleDiv = srate_reg[`EMAC_BIT_RANGE] ?
        (`EMAC_HIGH_BASE - {1'b0, srate_reg}) :
        (`EMAC_LOW_BASE - {1'b0, srate_reg});
    assign filterDiv = `EMAC_HIGH_BASE - {1'b0, filt_reg};

    emac_nco #(.ACC_W(32)) srcNco (
        .clk(clk),
        .nrst(nrst),
        .step(trimStep(srcStep, trim_reg[`EMAC_BIT_TRIM])),
        .tick(srcTick)
    );

    emac_div #(.CNT_W(9)) sampleDivider (
        .clk(clk),
        .nrst(nrst),
        .en(srcTick),
        .divisor(sampleDiv),
        .tick(sampleTick)
    );

    wire filtSrcTick;

    emac_nco #(.ACC_W(32)) filtNco (
        .clk(clk),
        .nrst(nrst),
        .step(trimStep(STEP_FI64[31:0], trim_reg[`EMAC_BIT_TRIM])),
        .tick(filtSrcTick)
    );

    emac_div #(.CNT_W(9)) filterDivider (
        .clk(clk),
        .nrst(nrst),
        .en(filtSrcTick),
        .divisor(filterDiv),
        .tick(filterTick)
    );

    // pin synchronisers; the first stage feeds only the second
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ackMeta_reg <= 1'b1;
            ackSync_reg <= 1'b1;
            rdMeta_reg <= 1'b1;
            rdSync_reg <= 1'b1;
            wrMeta_reg <= 1'b1;
            wrSync_reg <= 1'b1;
            wakeMeta_reg <= 1'b0;
            wakeSync_reg <= 1'b0;
        end else begin
            ackMeta_reg <= dma_acknowledge_in_n;
            ackSync_reg <= ackMeta_reg;
            rdMeta_reg <= ioReadN;
            rdSync_reg <= rdMeta_reg;
            wrMeta_reg <= ioWriteN;
            wrSync_reg <= wrMeta_reg;
            wakeMeta_reg <= analogWake;
            wakeSync_reg <= wakeMeta_reg;
        end
    end

    // extended dma needs ack and a command low; compatibility needs ack alone
    assign cmdLow = extDma ? (!ackSync_reg && (!rdSync_reg || !wrSync_reg)) : !ackSync_reg;
    // a byte counts once, when its acknowledge cycle ends
    assign byteDone = inCycle_reg && !cmdLow && (extDma || compDma);
    assign overflow = byteDone && (xferCnt_reg == `EMAC_CNT_MAX);
    assign heChange = fifo_half_empty_flag != heLast_reg;
    assign irqSet = (overflow && irqCtl_reg[`EMAC_BIT_OVF_IE])
        || (heChange && irqCtl_reg[`EMAC_BIT_HE_IE] && !extDma);
    assign wakeRise = wakeSync_reg && !wakeLast_reg;

    // register writes and software reset
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            srate_reg <= `EMAC_RST_ZERO;
            filt_reg <= FILT_RESET;
            rldLo_reg <= `EMAC_RST_RLD_LO;
            rldHi_reg <= `EMAC_RST_RLD_HI;
            mic_reg <= `EMAC_RST_MIC;
            irqCtl_reg <= 4'h0;
            dmaCtl_reg <= 4'h0;
            trim_reg <= `EMAC_RST_ZERO;
            fm_reg <= `EMAC_RST_FM;
        end else if (swReset) begin
            srate_reg <= `EMAC_RST_ZERO;
            filt_reg <= FILT_RESET;
        end else if (wrSel) begin
            case (regIndex)
                `EMAC_IDX_SRATE: srate_reg <= regWrData;
                `EMAC_IDX_FILT: filt_reg <= regWrData;
                `EMAC_IDX_RLD_LO: rldLo_reg <= regWrData;
                `EMAC_IDX_RLD_HI: rldHi_reg <= regWrData;
                `EMAC_IDX_MIC: mic_reg <= regWrData;
                `EMAC_IDX_IRQ: irqCtl_reg <= regWrData[7:4];
                `EMAC_IDX_DMA: dmaCtl_reg <= regWrData[7:4];
                `EMAC_IDX_TRIM: trim_reg <= regWrData;
                `EMAC_IDX_FM: fm_reg <= regWrData;
                default: srate_reg <= srate_reg;
            endcase
        end
    end

    // register reads; bits 3:0 of the control pair are live decodes
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            regRdData <= 8'h00;
        end else if (regRdEn) begin
            case (regIndex)
                `EMAC_IDX_SRATE: regRdData <= srate_reg;
                `EMAC_IDX_FILT: regRdData <= filt_reg;
                `EMAC_IDX_RLD_LO: regRdData <= rldLo_reg;
                `EMAC_IDX_RLD_HI: regRdData <= rldHi_reg;
                `EMAC_IDX_MIC: regRdData <= mic_reg;
                `EMAC_IDX_IRQ: regRdData <= {irqCtl_reg, irqCode(irqSelect)};
                `EMAC_IDX_DMA: regRdData <= {dmaCtl_reg, dmaCode(dmaSelect)};
                `EMAC_IDX_TRIM: regRdData <= trim_reg;
                `EMAC_IDX_FM: regRdData <= fm_reg;
                default: regRdData <= 8'h00;
            endcase
        end
    end

    // transfer counter and dma request
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            xferCnt_reg <= 16'h0000;
            dmaRunning <= 1'b0;
            dmaRequest <= 1'b0;
            inCycle_reg <= 1'b0;
            byteMoved <= 1'b0;
            blockIoMode <= 1'b1;
        end else begin
            byteMoved <= byteDone;
            blockIoMode <= !extDma;
            inCycle_reg <= cmdLow && (extDma || compDma);
            if (startXfer) begin
                xferCnt_reg <= {rldHi_reg, rldLo_reg};
                dmaRunning <= 1'b1;
            end else if (overflow) begin
                xferCnt_reg <= {rldHi_reg, rldLo_reg};
                dmaRunning <= autoInitMode;
            end else if (byteDone) begin
                xferCnt_reg <= xferCnt_reg + 1'b1;
            end
            // request drops once the acknowledge phase starts, never left floating
            dmaRequest <= (extDma || compDma) && dmaRunning && fifoReady
                && !cmdLow && !(overflow && !autoInitMode);
        end
    end

    // interrupt flag: an event in the clearing cycle wins
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irqLine <= 1'b0;
            irqDriveEn <= 1'b0;
            heLast_reg <= 1'b0;
        end else begin
            heLast_reg <= fifo_half_empty_flag;
            irqDriveEn <= audioActivate;
            if (irqSet) begin
                irqLine <= 1'b1;
            end else if (irqClear) begin
                irqLine <= 1'b0;
            end
        end
    end

    // power-up and wake mute timer
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            muteCnt_reg <= {MUTE_W{1'b0}};
            muting_reg <= 1'b1;
            wakeLast_reg <= 1'b0;
        end else begin
            wakeLast_reg <= wakeSync_reg;
            if (wakeRise) begin
                muteCnt_reg <= {MUTE_W{1'b0}};
                muting_reg <= 1'b1;
            end else if (muting_reg) begin
                if (muteCnt_reg >= MUTE_LAST) begin
                    muting_reg <= 1'b0;
                end else begin
                    muteCnt_reg <= muteCnt_reg + 1'b1;
                end
            end
        end
    end

    // analog side controls
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            line_output_left_mute <= 1'b1;
            line_output_right_mute <= 1'b1;
            micGain26 <= 1'b1;
            rate_trim_enable <= 1'b0;
            fm_level_high_bit <= 1'b1;
            fm_level_low_bit <= 1'b0;
        end else begin
            line_output_left_mute <= muting_reg && !trim_reg[`EMAC_BIT_NO_MUTE];
            line_output_right_mute <= muting_reg && !trim_reg[`EMAC_BIT_NO_MUTE];
            micGain26 <= mic_reg[`EMAC_BIT_MIC_EN];
            rate_trim_enable <= trim_reg[`EMAC_BIT_TRIM];
            fm_level_high_bit <= fm_reg[`EMAC_FM_HI];
            fm_level_low_bit <= fm_reg[`EMAC_FM_LO];
        end
    end
endmodule // emac_regs
`default_nettype wire

// ### verif/emac_regs_monitor.sv
// assertion checker for the extended-mode audio control registers
`default_nettype none
module emac_regs_monitor #(
    parameter MUTE_CYCLES = 50
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic audioActivate,
    input wire logic dma_acknowledge_in_n,
    input wire logic ioReadN,
    input wire logic dmaRequest,
    input wire logic dmaRunning,
    input wire logic byteMoved,
    input wire logic irqDriveEn,
    input wire logic line_output_left_mute,
    input wire logic line_output_right_mute,
    input wire logic micGain26,
    input wire logic rate_trim_enable,
    input wire logic fm_level_high_bit,
    input wire logic fm_level_low_bit,
    input wire logic sampleTick
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] muteCnt_reg;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // run length of muting, so a long bound needs no unrolled repetition
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            muteCnt_reg <= 32'h0000_0000;
        end else if (line_output_left_mute) begin
            muteCnt_reg <= muteCnt_reg + 32'h0000_0001;
        end else begin
            muteCnt_reg <= 32'h0000_0000;
        end
    end
    a_drq_needs_run: assert property (dmaRequest |-> dmaRunning)
        else $error("dma request without a running transfer");
    a_ack_drops_drq: assert property ((!dma_acknowledge_in_n && !ioReadN) [*4]
        |-> !dmaRequest)
        else $error("dma request not released in acknowledge phase");
    a_byte_single: assert property (byteMoved |=> !byteMoved)
        else $error("byte pulse longer than one cycle");
    a_mute_reset: assert property ($rose(nrst) |-> line_output_left_mute)
        else $error("outputs not muted after reset");
    a_mute_pair: assert property (line_output_left_mute == line_output_right_mute)
        else $error("left and right mute differ");
    a_mute_bound: assert property (muteCnt_reg <= MUTE_CYCLES + 4)
        else $error("mute held too long");
    a_drive_follow: assert property (irqDriveEn == $past(audioActivate))
        else $error("interrupt drive does not follow activate");
    a_reset_levels: assert property ($rose(nrst) |-> micGain26
        && fm_level_high_bit && !fm_level_low_bit && !rate_trim_enable)
        else $error("wrong level bits after reset");
    a_tick_single: assert property (sampleTick |=> !sampleTick)
        else $error("sample tick longer than one cycle");
    cover property (byteMoved);
    cover property ($fell(line_output_left_mute));
    cover property ($fell(dmaRunning));
endmodule // emac_regs_monitor
bind emac_regs emac_regs_monitor #(.MUTE_CYCLES(MUTE_CYCLES)) i_emac_regs_monitor (
    .clk(clk), .nrst(nrst), .audioActivate(audioActivate),
    .dma_acknowledge_in_n(dma_acknowledge_in_n), .ioReadN(ioReadN),
    .dmaRequest(dmaRequest), .dmaRunning(dmaRunning), .byteMoved(byteMoved),
    .irqDriveEn(irqDriveEn), .line_output_left_mute(line_output_left_mute),
    .line_output_right_mute(line_output_right_mute), .micGain26(micGain26),
    .rate_trim_enable(rate_trim_enable), .fm_level_high_bit(fm_level_high_bit),
    .fm_level_low_bit(fm_level_low_bit), .sampleTick(sampleTick));
`default_nettype wire

// ### verif/emac_dma_host.sv
// host dma controller model answering requests with acknowledge cycles
`default_nettype none
module emac_dma_host (
    input wire logic clk,
    input wire logic dmaRequest,
    input wire logic [3:0] holdCycles,
    output var logic ackN,
    output var logic readN,
    output var logic writeN
);
    timeunit 1ns;
    timeprecision 1ns;
    int i;
    initial begin
        {ackN, readN, writeN} = 3'b111;
        forever begin
            @(negedge clk);
            if (dmaRequest) begin
                // acknowledge leads the strobe, as a real controller does
                ackN = 1'b0;
                @(negedge clk);
                readN = 1'b0;
                i = 0;
                while (dmaRequest && i < 20) begin
                    @(negedge clk);
                    i++;
                end
                repeat (holdCycles) @(negedge clk);
                readN = 1'b1;
                @(negedge clk);
                ackN = 1'b1;
                repeat (2) @(negedge clk);
            end
        end
    end
endmodule // emac_dma_host
`default_nettype wire

// ### verif/tb.sv
// self-checking testbench for the extended-mode audio control registers
`include "emac_defines.vh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, nrst, swReset, regWrEn, regRdEn, audioActivate, irqClear, startXfer;
    logic autoInitMode, fifoReady, halfEmpty, ackN, readN, writeN, analogWake;
    logic [7:0] regIndex, regWrData, d, regRdData;
    logic [3:0] irqSelect, holdCycles;
    logic [1:0] dmaSelect;
    logic irqLine, irqDriveEn, dmaRequest, dmaRunning, blockIoMode, byteMoved;
    logic muteL, muteR, micGain26, trimEn, fmHi, fmLo, sampleTick, filterTick;
    int n_fail, n_compared, cyc, k, nBytes;
    logic [7:0] idxTab [0:6] = '{8'ha1, 8'ha2, 8'ha4, 8'ha5, 8'ha9, 8'hba, 8'hbc};
    logic [7:0] rstTab [0:6] = '{8'h00, 8'h00, 8'h00, 8'hf8, 8'h04, 8'h00, 8'hb6};
    logic [3:0] irqTab [0:4] = '{4'h5, 4'h7, 4'ha, 4'h2, 4'h9};
    logic [3:0] codeTab [0:4] = '{4'h5, 4'ha, 4'hf, 4'h0, 4'h0};
    emac_regs #(.MUTE_CYCLES(50)) i_emac_regs (.clk(clk), .nrst(nrst), .swReset(swReset),
        .regIndex(regIndex), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regRdData(regRdData), .irqSelect(irqSelect), .dmaSelect(dmaSelect),
        .audioActivate(audioActivate), .irqClear(irqClear), .irqLine(irqLine),
        .irqDriveEn(irqDriveEn), .startXfer(startXfer), .autoInitMode(autoInitMode),
        .fifoReady(fifoReady), .fifo_half_empty_flag(halfEmpty),
        .dma_acknowledge_in_n(ackN), .ioReadN(readN), .ioWriteN(writeN),
        .dmaRequest(dmaRequest), .dmaRunning(dmaRunning), .blockIoMode(blockIoMode),
        .byteMoved(byteMoved), .analogWake(analogWake), .line_output_left_mute(muteL),
        .line_output_right_mute(muteR), .micGain26(micGain26), .rate_trim_enable(trimEn),
        .fm_level_high_bit(fmHi), .fm_level_low_bit(fmLo), .sampleTick(sampleTick),
        .filterTick(filterTick));
    emac_dma_host i_emac_dma_host (.clk(clk), .dmaRequest(dmaRequest),
        .holdCycles(holdCycles), .ackN(ackN), .readN(readN), .writeN(writeN));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) if (byteMoved === 1'b1) nBytes++;
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic near(input string name, input int exp, input int got);
        n_compared++;
        if (got - exp > 3 || exp - got > 3) begin
            n_fail++;
            $display("ERROR %s expected %0d seen %0d", name, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] val);
        regIndex = idx;
        regWrData = val;
        regWrEn = 1'b1;
        @(negedge clk);
        regWrEn = 1'b0;
        @(negedge clk);
    endtask
    task automatic rd(input logic [7:0] idx, output logic [7:0] val);
        regIndex = idx;
        regRdEn = 1'b1;
        @(negedge clk);
        val = regRdData;
        regRdEn = 1'b0;
        @(negedge clk);
    endtask
    task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] v;
        rd(idx, v);
        check("register read", exp, v);
    endtask
    // cycles from one tick to the n-th following one
    task automatic measure(input logic filt, input int n, output int c);
        int t;
        t = 0;
        c = 0;
        while (t <= n && c < 20000) begin
            @(negedge clk);
            if ((filt ? filterTick : sampleTick) === 1'b1) t++;
            if (t > 0) c++;
        end
        c = c - 1;
    endtask
    function automatic int expCyc(input longint n, input longint dv, input longint src);
        return int'(n * `EMAC_CLK_HZ * dv / src);
    endfunction
    task automatic wait_bytes(input int n);
        int t;
        t = 0;
        while (nBytes < n && t < 3000) begin
            @(negedge clk);
            t++;
        end
        check("byte count", 16'(n), 16'(nBytes));
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
        @(negedge clk);
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        #(40 * 30000);
        n_fail++;
        report_and_stop();
    end
    initial begin
        {nrst, swReset, regWrEn, regRdEn, audioActivate, irqClear, startXfer} = 7'h00;
        {autoInitMode, fifoReady, halfEmpty, analogWake} = 4'h0;
        {regIndex, regWrData, irqSelect, holdCycles, dmaSelect} = 26'h000_0000;
        n_fail = 0;
        n_compared = 0;
        nBytes = 0;
        repeat (10) @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
        check("mute after reset", 16'h0001, 16'({muteL, muteR} == 2'b11));
        check("mic gain", 16'h0001, 16'(micGain26));
        check("fm level", 16'h0002, 16'({fmHi, fmLo}));
        for (k = 0; k < 7; k++) rdchk(idxTab[k], rstTab[k]);
        for (k = 0; k < 5; k++) begin
            irqSelect = irqTab[k];
            dmaSelect = 2'(k);
            rd(`EMAC_IDX_IRQ, d);
            check("irq code", 16'(codeTab[k]), 16'(d[3:0]));
            rd(`EMAC_IDX_DMA, d);
            check("dma code", 16'(k == 2 ? 4'h0 : codeTab[k == 3 ? 2 : k % 4]), 16'(d[3:0]));
        end
        wr(`EMAC_IDX_IRQ, 8'h7f);
        rd(`EMAC_IDX_IRQ, d);
        check("irq control", 16'h0060, 16'(d & 8'h6f));
        wr(8'ha0, 8'h5a);
        rdchk(8'ha0, 8'h00);
        wr(`EMAC_IDX_SRATE, 8'h7e);
        rdchk(`EMAC_IDX_SRATE, 8'h7e);
        measure(1'b0, 16, cyc);
        near("low rate", expCyc(16, 2, `EMAC_SRC_LO_HZ), cyc);
        check("mute expired", 16'h0000, 16'(muteL));
        wr(`EMAC_IDX_SRATE, 8'hfe);
        measure(1'b0, 16, cyc);
        near("high rate", expCyc(16, 2, `EMAC_SRC_HI_HZ), cyc);
        wr(`EMAC_IDX_FILT, 8'hf0);
        measure(1'b1, 8, cyc);
        near("filter rate", expCyc(8, 16, `EMAC_FILT_SRC_HZ), cyc);
        pulse(swReset);
        rdchk(`EMAC_IDX_SRATE, 8'h00);
        rd(`EMAC_IDX_MIC, d);
        wr(`EMAC_IDX_MIC, d & 8'hfb);
        check("mic gain off", 16'h0000, 16'(micGain26));
        for (k = 0; k < 4; k++) begin
            wr(`EMAC_IDX_FM, {2'(k), 6'b110110});
            check("fm level", 16'(k), 16'({fmHi, fmLo}));
        end
        wr(`EMAC_IDX_TRIM, 8'h40);
        check("rate trim", 16'h0001, 16'(trimEn));
        analogWake = 1'b1;
        repeat (25) @(negedge clk);
        check("wake mute", 16'h0001, 16'(muteR));
        wr(`EMAC_IDX_TRIM, 8'h20);
        check("mute disabled", 16'h0000, 16'(muteL));
        wr(`EMAC_IDX_IRQ, 8'h10);
        check("irq drive off", 16'h0000, 16'(irqDriveEn));
        audioActivate = 1'b1;
        repeat (2) @(negedge clk);
        check("irq drive on", 16'h0001, 16'(irqDriveEn));
        wr(`EMAC_IDX_DMA, 8'h00);
        check("block io", 16'h0001, 16'(blockIoMode));
        halfEmpty = 1'b1;
        repeat (4) @(negedge clk);
        check("half empty masked", 16'h0000, 16'(irqLine));
        wr(`EMAC_IDX_IRQ, 8'h20);
        halfEmpty = 1'b0;
        repeat (4) @(negedge clk);
        check("half empty irq", 16'h0001, 16'(irqLine));
        pulse(irqClear);
        wr(`EMAC_IDX_IRQ, 8'h00);
        wr(`EMAC_IDX_RLD_LO, 8'hfd);
        wr(`EMAC_IDX_RLD_HI, 8'hff);
        fifoReady = 1'b1;
        pulse(startXfer);
        repeat (10) @(negedge clk);
        check("request disabled", 16'h0000, 16'(dmaRequest));
        wr(`EMAC_IDX_DMA, 8'h40);
        check("dma mode", 16'h0000, 16'(blockIoMode));
        pulse(startXfer);
        wait_bytes(3);
        repeat (40) @(negedge clk);
        check("normal stop", 16'h0003, 16'(nBytes));
        check("request stopped", 16'h0000, 16'({dmaRequest, dmaRunning}));
        check("overflow masked", 16'h0000, 16'(irqLine));
        wr(`EMAC_IDX_IRQ, 8'h40);
        wr(`EMAC_IDX_DMA, 8'h20);
        autoInitMode = 1'b1;
        holdCycles = 4'h3;
        pulse(startXfer);
        wait_bytes(6);
        repeat (2) @(negedge clk);
        check("overflow irq", 16'h0001, 16'(irqLine));
        pulse(irqClear);
        wait_bytes(8);
        check("irq cleared", 16'h0000, 16'(irqLine));
        wait_bytes(9);
        repeat (2) @(negedge clk);
        check("reload overflow", 16'h0001, 16'(irqLine));
        wr(`EMAC_IDX_DMA, 8'h00);
        repeat (40) @(negedge clk);
        check("request off", 16'h0000, 16'(dmaRequest));
        report_and_stop();
    end
endmodule // tb
`default_nettype wire
